// ### logic/crq_pkg.sv
package crq_pkg;
  // ==========================================
  // Bus timing, vector table and state encodings
  // ==========================================
  localparam int CRQ_CLK_MHZ = 200;
  localparam logic [15:0] CRQ_VEC_BASE = 16'h0000;
  localparam int CRQ_VEC_SHIFT = 2;
  localparam int CRQ_STRB_RST = 1;
  typedef enum logic [2:0] {
    CRQ_IDLE,
    CRQ_T1,
    CRQ_T2,
    CRQ_T3,
    CRQ_T4
  } crq_bus_t;
  typedef enum logic [2:0] {
    CRQ_EXEC,
    CRQ_ACK1,
    CRQ_ACK2,
    CRQ_VLO,
    CRQ_VHI,
    CRQ_JUMP
  } crq_seq_t;
endpackage

// ### logic/crq_bus_cycle.sv
`timescale 1ns/1ps
module crq_bus_cycle
  import crq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic is_ack,
  input wire logic xfer_ready,
  output logic rd_strobe_n,
  output logic ack_strobe_n,
  output logic busy,
  output logic done
);
  // ==========================================
  // One bus cycle t1..t4 with waits in t3
  // ==========================================
  crq_bus_t st_ff, nxt_st;
  logic ack_ff, nxt_ack;
  logic rd_n_ff, nxt_rd_n;
  logic ia_n_ff, nxt_ia_n;
  logic done_ff, nxt_done;

  always_comb begin
    nxt_st = st_ff;
    nxt_ack = ack_ff;
    nxt_done = 1'b0;
    case (st_ff)
      CRQ_IDLE: begin
        if (start) begin
          nxt_st = CRQ_T1;
          nxt_ack = is_ack;
        end
      end
      CRQ_T1: nxt_st = CRQ_T2;
      CRQ_T2: nxt_st = CRQ_T3;
      // Ready is used raw; the partner must present it synchronised
      CRQ_T3: begin
        if (xfer_ready) begin
          nxt_st = CRQ_T4;
        end
      end
      CRQ_T4: begin
        nxt_st = CRQ_IDLE;
        nxt_done = 1'b1;
      end
      default: nxt_st = CRQ_IDLE;
    endcase
    // Strobes low through t2, t3 and waits; high by t4 once bus floated
    nxt_rd_n = !((nxt_st == CRQ_T2 || nxt_st == CRQ_T3) && !nxt_ack);
    nxt_ia_n = !((nxt_st == CRQ_T2 || nxt_st == CRQ_T3) && nxt_ack);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_ff <= CRQ_IDLE;
      ack_ff <= 1'b0;
      rd_n_ff <= 1'(CRQ_STRB_RST);
      ia_n_ff <= 1'(CRQ_STRB_RST);
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ack_ff <= nxt_ack;
      rd_n_ff <= nxt_rd_n;
      ia_n_ff <= nxt_ia_n;
      done_ff <= nxt_done;
    end
  end

  assign rd_strobe_n = rd_n_ff;
  assign ack_strobe_n = ia_n_ff;
  assign busy = (st_ff != CRQ_IDLE);
  assign done = done_ff;
endmodule

// ### logic/crq_core.sv
// Notes on behaviour
// - Transfer acknowledge is active high; device drives it to finish transfer.
// - Interrupt request sampled as a level in last cycle of each instruction.
// - Accepted interrupt branches to handler fetched from vector table in memory.
// - Interrupt request ignored while enable flag clear, honoured while set.
// - Acknowledge strobe low in t2, t3 and waits; never floated.
`timescale 1ns/1ps
module crq_core
  import crq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic maskable_irq_in,
  input wire logic xfer_ready,
  input wire logic instr_last,
  input wire logic irq_enable,
  input wire logic read_req,
  input wire logic [15:0] bus_data_in,
  output logic rd_strobe_n,
  output logic irq_ack_strobe_n,
  output logic [7:0] irq_vector,
  output logic [15:0] handler_addr,
  output logic branch_pulse,
  output logic irq_ack_busy
);
  // ==========================================
  // Interrupt sequencing
  // ==========================================
  crq_seq_t seq_ff, nxt_seq;
  logic [7:0] vec_ff, nxt_vec;
  logic [15:0] addr_ff, nxt_addr;
  logic br_ff, nxt_br;
  logic start, is_ack, busy, done, take_irq;
  logic abusy_ff, nxt_abusy;

  // ==========================================
  // Request pin synchroniser
  // ==========================================
  // The source is asynchronous; two stages keep metastability off the sampler
  logic irq_meta_ff, nxt_irq_meta;
  logic irq_sync_ff, nxt_irq_sync;

  always_comb begin
    nxt_irq_meta = maskable_irq_in;
    nxt_irq_sync = irq_meta_ff;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_meta_ff <= 1'b0;
      irq_sync_ff <= 1'b0;
    end else begin
      irq_meta_ff <= nxt_irq_meta;
      irq_sync_ff <= nxt_irq_sync;
    end
  end

  // Level sample only when the instruction ends and the flag is set
  assign take_irq = instr_last && irq_enable && irq_sync_ff;

  always_comb begin
    nxt_seq = seq_ff;
    nxt_vec = vec_ff;
    nxt_addr = addr_ff;
    nxt_br = 1'b0;
    start = 1'b0;
    is_ack = 1'b0;
    case (seq_ff)
      CRQ_EXEC: begin
        if (take_irq && !busy) begin
          nxt_seq = CRQ_ACK1;
          start = 1'b1;
          is_ack = 1'b1;
        end else if (read_req && !busy) begin
          start = 1'b1;
        end
      end
      // Two acknowledge cycles; the second returns the type number
      CRQ_ACK1: begin
        if (done) begin
          nxt_seq = CRQ_ACK2;
          start = 1'b1;
          is_ack = 1'b1;
        end
      end
      CRQ_ACK2: begin
        if (done) begin
          nxt_vec = bus_data_in[7:0];
          nxt_seq = CRQ_VLO;
          start = 1'b1;
        end
      end
      // Handler address read from table in memory
      CRQ_VLO: begin
        if (done) begin
          nxt_addr = bus_data_in;
          nxt_seq = CRQ_JUMP;
        end
      end
      CRQ_JUMP: begin
        nxt_br = 1'b1;
        nxt_seq = CRQ_EXEC;
      end
      default: nxt_seq = CRQ_EXEC;
    endcase
    nxt_abusy = (nxt_seq != CRQ_EXEC);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      seq_ff <= CRQ_EXEC;
      vec_ff <= 8'h00;
      addr_ff <= 16'h0000;
      br_ff <= 1'b0;
      abusy_ff <= 1'b0;
    end else begin
      seq_ff <= nxt_seq;
      vec_ff <= nxt_vec;
      addr_ff <= nxt_addr;
      br_ff <= nxt_br;
      abusy_ff <= nxt_abusy;
    end
  end

  crq_bus_cycle u_bus (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(start),
    .is_ack(is_ack),
    .xfer_ready(xfer_ready),
    .rd_strobe_n(rd_strobe_n),
    .ack_strobe_n(irq_ack_strobe_n),
    .busy(busy),
    .done(done)
  );

  assign irq_vector = vec_ff;
  assign handler_addr = addr_ff;
  assign branch_pulse = br_ff;
  assign irq_ack_busy = abusy_ff;

  // ==========================================
  // Checks
  // ==========================================
  property p_mask;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_EXEC && !irq_enable && !read_req) |=> seq_ff == CRQ_EXEC;
  endproperty
  a_mask: assert property (p_mask) else $error("irq taken while masked");
  property p_take;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_EXEC && take_irq && !busy) |=> seq_ff == CRQ_ACK1;
  endproperty
  a_take: assert property (p_take) else $error("irq not taken");
  property p_ack_low;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_ACK1 && $fell(irq_ack_strobe_n)) |-> rd_strobe_n;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("both strobes low");
  property p_ack_seen;
    @(posedge ref_clk) disable iff (reset)
      $rose(seq_ff == CRQ_ACK1) |-> ##[1:3] !irq_ack_strobe_n;
  endproperty
  a_ack_seen: assert property (p_ack_seen) else $error("ack strobe missing");
  property p_rd_ack;
    @(posedge ref_clk) disable iff (reset)
      !rd_strobe_n |-> irq_ack_strobe_n;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read during ack");
  property p_wait;
    @(posedge ref_clk) disable iff (reset)
      (!rd_strobe_n && !xfer_ready) |=> !rd_strobe_n;
  endproperty
  a_wait: assert property (p_wait) else $error("strobe ended during wait");
  property p_branch;
    @(posedge ref_clk) disable iff (reset)
      branch_pulse |-> seq_ff == CRQ_EXEC ##1 !branch_pulse;
  endproperty
  a_branch: assert property (p_branch) else $error("branch pulse long");
  property p_addr;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_VLO && done) |=> handler_addr == $past(bus_data_in);
  endproperty
  a_addr: assert property (p_addr) else $error("handler address wrong");
  property p_sync_take;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_EXEC && !busy && instr_last && irq_enable && $past(maskable_irq_in, 2))
      |=> seq_ff == CRQ_ACK1;
  endproperty
  a_sync_take: assert property (p_sync_take) else $error("synchronised irq not taken");
  property p_low_level;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_EXEC && !$past(maskable_irq_in, 2)) |=> seq_ff == CRQ_EXEC;
  endproperty
  a_low_level: assert property (p_low_level) else $error("irq taken while low");
  property p_not_last;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_EXEC && !instr_last) |=> seq_ff == CRQ_EXEC;
  endproperty
  a_not_last: assert property (p_not_last) else $error("irq taken mid instruction");
  property p_vec;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_ACK2 && done) |=> irq_vector == $past(bus_data_in[7:0]);
  endproperty
  a_vec: assert property (p_vec) else $error("type byte wrong");
  property p_vec_read;
    @(posedge ref_clk) disable iff (reset)
      $rose(seq_ff == CRQ_VLO) |-> ##[1:3] !rd_strobe_n;
  endproperty
  a_vec_read: assert property (p_vec_read) else $error("table read missing");
  property p_ack_wait;
    @(posedge ref_clk) disable iff (reset)
      (!irq_ack_strobe_n && !xfer_ready) |=> !irq_ack_strobe_n;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("ack strobe ended in wait");
  property p_ack_only;
    @(posedge ref_clk) disable iff (reset)
      !irq_ack_strobe_n |-> (seq_ff == CRQ_ACK1 || seq_ff == CRQ_ACK2);
  endproperty
  a_ack_only: assert property (p_ack_only) else $error("ack strobe outside ack");
  property p_mask_ack;
    @(posedge ref_clk) disable iff (reset)
      (seq_ff == CRQ_EXEC && !irq_enable) |=> irq_ack_strobe_n;
  endproperty
  a_mask_ack: assert property (p_mask_ack) else $error("ack while masked");
endmodule

// ### tb/crq_mem_model.sv
`timescale 1ns/1ps
// ====================
// Memory and type-byte source
// ====================
module crq_mem_model (
  input wire logic ref_clk,
  input wire logic rd_strobe_n,
  input wire logic irq_ack_strobe_n,
  input wire logic [3:0] wait_n,
  input wire logic [7:0] type_byte,
  input wire logic [15:0] word,
  output logic xfer_ready,
  output logic [15:0] bus_data_in
);
  logic [3:0] cnt;
  logic [1:0] hold;
  initial begin
    xfer_ready = 1'b0;
    bus_data_in = 16'h0000;
    cnt = 4'h0;
    hold = 2'h0;
  end
  // Data turns over once released so stale values never pass
  always @(negedge ref_clk) begin
    if (!rd_strobe_n || !irq_ack_strobe_n) begin
      bus_data_in <= irq_ack_strobe_n ? word : {8'h00, type_byte};
      // Ready first seen in t3 after wait_n wait states
      xfer_ready <= (cnt > wait_n);
      cnt <= cnt + 4'h1;
      hold <= 2'h2;
    end else begin
      xfer_ready <= 1'b0;
      cnt <= 4'h0;
      if (hold != 2'h0) hold <= hold - 2'h1;
      else bus_data_in <= ~bus_data_in;
    end
  end
endmodule

// ### tb/cpu_ready_and_irq_sampling_tb.sv
`timescale 1ns/1ps
module cpu_ready_and_irq_sampling_tb;
  import crq_pkg::*;
  logic ref_clk = 1'b0, reset = 1'b1, irq = 1'b0, last = 1'b0, en = 1'b0, rreq = 1'b0;
  logic xrdy, rd_n, ack_n, br, abusy;
  logic [3:0] wait_n = 4'h0;
  logic [15:0] din, haddr, word = 16'h0000;
  logic [7:0] vec, tbyte = 8'h00;
  int bad_count = 0, n_tests = 0, rd_lo = 0, ack_lo = 0, br_n = 0;
  int rd_b = 0, ack_b = 0, br_b = 0;
  crq_core dut (.ref_clk(ref_clk), .reset(reset), .maskable_irq_in(irq), .xfer_ready(xrdy),
    .instr_last(last), .irq_enable(en), .read_req(rreq), .bus_data_in(din),
    .rd_strobe_n(rd_n), .irq_ack_strobe_n(ack_n), .irq_vector(vec), .handler_addr(haddr),
    .branch_pulse(br), .irq_ack_busy(abusy));
  crq_mem_model mem (.ref_clk(ref_clk), .rd_strobe_n(rd_n), .irq_ack_strobe_n(ack_n),
    .wait_n(wait_n), .type_byte(tbyte), .word(word), .xfer_ready(xrdy), .bus_data_in(din));
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    rd_lo <= rd_lo + (rd_n === 1'b0);
    ack_lo <= ack_lo + (ack_n === 1'b0);
    br_n <= br_n + (br === 1'b1);
  end
  // ====================
  // Checking and closing
  // ====================
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic clr(input logic [3:0] k);
    @(negedge ref_clk);
    wait_n = k;
    rd_b = rd_lo;
    ack_b = ack_lo;
    br_b = br_n;
  endtask
  // ====================
  // Scenarios
  // ====================
  task automatic t_read(input logic [3:0] k);
    clr(k);
    rreq = 1'b1;
    @(negedge ref_clk);
    rreq = 1'b0;
    repeat (30) @(negedge ref_clk);
    check(16'(rd_lo - rd_b), 16'(k) + 16'h2);
    check(16'(ack_lo - ack_b), 16'h0000);
    $display("read test done, waits=%0d", k);
  endtask
  // Pin leads the last-cycle mark by the synchroniser depth; a read asked
  // in the same cycle loses to the interrupt
  task automatic t_irq(input logic e, input logic l, input logic [3:0] k);
    int i;
    clr(k);
    tbyte = tbyte + 8'h35;
    word = word + 16'h1c47;
    {irq, en} = {1'b1, e};
    repeat (2) @(negedge ref_clk);
    {last, rreq} = {l, l};
    @(negedge ref_clk);
    {last, rreq} = 2'b00;
    check(16'(abusy), 16'(e & l));
    irq = 1'b0;
    for (i = 0; i < 80 && br_n == br_b; i++) @(negedge ref_clk);
    check(16'(br_n - br_b), 16'(e & l));
    check(16'(ack_lo - ack_b), (e & l) ? 16'(2 * (k + 2)) : 16'h0000);
    check(16'(rd_lo - rd_b), l ? 16'(k + 2) : 16'h0000);
    if (e & l) begin
      check(16'(vec), 16'(tbyte));
      check(haddr, word);
    end
    check(16'(abusy), 16'h0000);
    $display("irq test done, en=%0d last=%0d", e, l);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
    check(16'({rd_n, ack_n}), 16'h0003);
    t_read(4'h0);
    t_read(4'h3);
    t_irq(1'b0, 1'b1, 4'h0);
    t_irq(1'b1, 1'b0, 4'h0);
    t_irq(1'b1, 1'b1, 4'h0);
    t_irq(1'b1, 1'b1, 4'h2);
    finish_test();
  end
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
endmodule
